// ===== hdl/dut_consts.vh
// constants for the dual up/down timer block
`ifndef DUT_CONSTS_VH
`define DUT_CONSTS_VH
`define DUT_ADDR_CORE_CTRL   16'hff48
`define DUT_ADDR_AUX_CTRL    16'hff46
`define DUT_ADDR_CORE_TIMER  16'hfe48
`define DUT_ADDR_AUX_TIMER   16'hfe46
`define DUT_ADDR_CAPTURE_RELOAD_REGISTER      16'hfe4a
`define DUT_ADDR_STATUS      16'hfe4c
`define DUT_CTRL_RESET       16'h0000
`define DUT_F_ISEL_LO        0
`define DUT_F_MODE_LO        3
`define DUT_F_RUN            6
`define DUT_F_DIR            7
`define DUT_F_EXTDIR         8
`define DUT_F_OE             9
`define DUT_F_OTL            10
`define DUT_F_SRLD           15
`define DUT_F_CAPSRC         9
`define DUT_F_CEDGE_LO       12
`define DUT_F_CLR            14
`define DUT_F_CAPEN          15
`define DUT_CORE_CTRL_MASK   16'h87ff
`define DUT_AUX_CTRL_MASK    16'hf3df
`define DUT_PRESCALE_BASE    4
`endif

// ===== hdl/dut_timer.v
// dual 16-bit up/down timer block with capture register
//
// Strobed register access was left to the implementer.
`include "dut_consts.vh"

// What this block does
// [R01] core timer counts only while core run bit is set
// [R02] gated mode advances only with run set and gate active
// [R03] with external direction off, direction bit alone picks up or down
// [R04] with external direction on, pin picks direction, direction bit inverts it
// [R05] direction change takes effect at once, running or stopped
// [R06] core wrap toggles the latch; software may write the latch directly
// [R07] output enable routes latch to pin, else ordinary port value
// [R08] latch feeds auxiliary counter input internally, regardless of pin
// [R09] core wrap event offered as direct pulse for capture/compare timers
// [R10] mode 000 is timer mode, one step per prescaled tick
// [R11] input select n gives prescale 4 times 2 to the n
// [R12] modes 010/011 are gated, mode bit 0 picks gate level
// [R13] gate level changes never raise an interrupt request
// [R14] mode 001 counts on selected pin edges; 000 none, 1xx reserved
// [R15] external count source holds each level at least 4 cycles
// [R16] auxiliary timer has same modes but no latch or output
// [R17] shared functions share bit positions in both control registers
// [R18] auxiliary mode 00 timer, 01 counter, 10 gated low, 11 gated high
// [R19] auxiliary run bit stops or runs the auxiliary timer
// [R20] capture edge 00 off, 01 rising, 10 falling, 11 either
// [R21] clear-on-capture clears auxiliary timer on capture, else untouched
// [R22] core control layout: isel, mode, run, dir, extdir, oe, latch, reload
// [R23] capture copies auxiliary timer, sets flag, then optional clear
// [R24] 16-bit timers wrap both ways and reset to zero
// [R25] external inputs synchronised; edges give one-cycle enables
module dut_timer #(
	parameter WIDTH = 16
) (
	input  wire              clk,
	input  wire              reset,
	input  wire [15:0]       addr,
	input  wire [15:0]       wdata,
	input  wire              wr,
	input  wire              rd,
	output reg  [15:0]       rdata,
	input  wire              core_gate_count_pin,
	input  wire              core_dir_pin,
	input  wire              aux_gate_count_pin,
	input  wire              aux_dir_pin,
	input  wire              capture_input_pin,
	input  wire              port_out_value,
	output wire              toggle_output_pin,
	output wire              core_wrap_pulse,
	output reg               capture_irq_flag
);

	reg  [15:0]      core_ctrl_q;
	reg  [15:0]      aux_ctrl_q;
	reg  [WIDTH-1:0] core_q;
	reg  [WIDTH-1:0] aux_q;
	reg  [WIDTH-1:0] capture_reload_register_q;
	reg  [9:0]       pre_q;
	reg  [4:0]       s1_q;
	reg  [4:0]       s2_q;
	reg  [4:0]       s3_q;
	reg              otl_prev_q;
	reg  [15:0]      rdata_d;

	// prescaler tick for a given select code
	function tick_of;
		input [2:0] sel;
		input [9:0] pre;
		reg   [9:0] m;
		begin
			m = (10'h004 << sel) - 10'h001;
			tick_of = ((pre & m) == m);
		end
	endfunction

	// direction: 1 means down
	function dir_down;
		input dir_bit;
		input ext_en;
		input pin;
		begin
			dir_down = ext_en ? (pin ^ dir_bit) : dir_bit;
		end
	endfunction

	// counter edge select on a sync'd input
	function edge_hit;
		input [1:0] sel;
		input       cur;
		input       prev;
		begin
			case (sel)
				2'h1: edge_hit = cur & ~prev;
				2'h2: edge_hit = ~cur & prev;
				2'h3: edge_hit = cur ^ prev;
				default: edge_hit = 1'b0;
			endcase
		end
	endfunction

	wire [4:0] pin_raw = {capture_input_pin, aux_dir_pin, aux_gate_count_pin,
		core_dir_pin, core_gate_count_pin};

	// [R25] two-stage sync then edge history
	// only the second and third stages are read by logic; the first may be metastable
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
			always @(posedge clk) begin
				if (reset) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= pin_raw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
				end
			end
		end
	endgenerate

	wire c_gate = s2_q[0];
	wire c_dpin = s2_q[1];
	wire a_gate = s2_q[2];
	wire a_dpin = s2_q[3];
	wire cap_in = s2_q[4];

	// [R22] core control fields
	wire [2:0] c_isel = core_ctrl_q[`DUT_F_ISEL_LO+2:`DUT_F_ISEL_LO];
	wire [2:0] c_mode = core_ctrl_q[`DUT_F_MODE_LO+2:`DUT_F_MODE_LO];
	wire       c_run  = core_ctrl_q[`DUT_F_RUN];
	wire       c_otl  = core_ctrl_q[`DUT_F_OTL];
	wire       c_srld = core_ctrl_q[`DUT_F_SRLD];
	// [R17] same positions in auxiliary control
	wire [2:0] a_isel = aux_ctrl_q[`DUT_F_ISEL_LO+2:`DUT_F_ISEL_LO];
	wire [1:0] a_mode = aux_ctrl_q[`DUT_F_MODE_LO+1:`DUT_F_MODE_LO];
	wire       a_run  = aux_ctrl_q[`DUT_F_RUN];
	wire [1:0] cedge  = aux_ctrl_q[`DUT_F_CEDGE_LO+1:`DUT_F_CEDGE_LO];
	wire       a_clr  = aux_ctrl_q[`DUT_F_CLR];
	wire       a_capen = aux_ctrl_q[`DUT_F_CAPEN];

	// [R05] direction applied combinationally, no latching
	// [R03] [R04] direction mapping
	wire c_down = dir_down(core_ctrl_q[`DUT_F_DIR], core_ctrl_q[`DUT_F_EXTDIR], c_dpin);
	wire a_down = dir_down(aux_ctrl_q[`DUT_F_DIR], aux_ctrl_q[`DUT_F_EXTDIR], a_dpin);

	// [R10] [R11] prescaled ticks, each timer its own select
	wire c_tick = tick_of(c_isel, pre_q);
	wire a_tick = tick_of(a_isel, pre_q);

	// [R01] [R02] [R12] [R14] core step enable; 1xx modes do nothing
	reg c_step;
	always @* begin
		c_step = 1'b0;
		case (c_mode)
			3'h0: c_step = c_run & c_tick;
			3'h1: c_step = c_run & ~c_isel[2] & edge_hit(c_isel[1:0], c_gate, s3_q[0]);
			3'h2: c_step = c_run & c_tick & ~c_gate;
			3'h3: c_step = c_run & c_tick & c_gate;
			default: c_step = 1'b0;
		endcase
	end

	// [R24] wrap detection both ways
	wire c_wrap = c_step & (c_down ? (core_q == {WIDTH{1'b0}}) : (core_q == {WIDTH{1'b1}}));
	// [R09] direct wrap pulse
	assign core_wrap_pulse = c_wrap;

	// [R08] latch transitions by wrap only feed aux counter
	wire otl_cur = c_otl;
	wire otl_hw_edge = otl_prev_q;

	// [R16] [R18] [R19] aux step enable
	reg a_step;
	always @* begin
		a_step = 1'b0;
		case (a_mode)
			2'h0: a_step = a_run & a_tick;
			2'h1: a_step = a_run & (a_isel[2] ?
				(otl_hw_edge & edge_hit(a_isel[1:0], otl_cur, ~otl_cur)) :
				edge_hit(a_isel[1:0], a_gate, s3_q[2]));
			2'h2: a_step = a_run & a_tick & ~a_gate;
			2'h3: a_step = a_run & a_tick & a_gate;
			default: a_step = 1'b0;
		endcase
	end

	// [R20] capture edge on synced pin
	wire cap_hit = edge_hit(cedge, cap_in, s3_q[4]);

	// [R07] alternate output or plain port value
	assign toggle_output_pin = core_ctrl_q[`DUT_F_OE] ? c_otl : port_out_value;

	wire wr_cc = wr & (addr == `DUT_ADDR_CORE_CTRL);
	wire wr_ac = wr & (addr == `DUT_ADDR_AUX_CTRL);
	wire wr_ct = wr & (addr == `DUT_ADDR_CORE_TIMER);
	wire wr_at = wr & (addr == `DUT_ADDR_AUX_TIMER);
	wire wr_cr = wr & (addr == `DUT_ADDR_CAPTURE_RELOAD_REGISTER);
	wire wr_st = wr & (addr == `DUT_ADDR_STATUS);

	// free-running prescaler shared by both timers
	always @(posedge clk) begin
		if (reset) begin
			pre_q <= 10'h000;
			otl_prev_q <= 1'b0;
		end else begin
			pre_q <= pre_q + 10'h001;
			otl_prev_q <= c_wrap;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			core_ctrl_q <= `DUT_CTRL_RESET;
		end else begin
			if (wr_cc) begin
				core_ctrl_q <= wdata & `DUT_CORE_CTRL_MASK;
			end
			// [R06] wrap toggles latch; wins over a same-cycle write
			if (c_wrap) begin
				core_ctrl_q[`DUT_F_OTL] <= ~c_otl;
			end
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			aux_ctrl_q <= `DUT_CTRL_RESET;
		end else if (wr_ac) begin
			aux_ctrl_q <= wdata & `DUT_AUX_CTRL_MASK;
		end
	end

	// core timer: reload on wrap when enabled
	always @(posedge clk) begin
		if (reset) begin
			core_q <= {WIDTH{1'b0}};
		end else if (wr_ct) begin
			core_q <= wdata[WIDTH-1:0];
		end else if (c_wrap & c_srld) begin
			core_q <= capture_reload_register_q;
		end else if (c_step) begin
			core_q <= c_down ? core_q - 1'b1 : core_q + 1'b1;
		end
	end

	// [R23] [R21] capture then optional clear
	always @(posedge clk) begin
		if (reset) begin
			aux_q <= {WIDTH{1'b0}};
		end else if (wr_at) begin
			aux_q <= wdata[WIDTH-1:0];
		end else if (cap_hit & a_clr) begin
			aux_q <= {WIDTH{1'b0}};
		end else if (a_step) begin
			aux_q <= a_down ? aux_q - 1'b1 : aux_q + 1'b1;
		end
	end

	// capture beats a same-cycle software write
	always @(posedge clk) begin
		if (reset) begin
			capture_reload_register_q <= {WIDTH{1'b0}};
		end else if (cap_hit & a_capen) begin
			capture_reload_register_q <= aux_q;
		end else if (wr_cr) begin
			capture_reload_register_q <= wdata[WIDTH-1:0];
		end
	end

	// [R13] flag only from capture edges, set wins over clear
	always @(posedge clk) begin
		if (reset) begin
			capture_irq_flag <= 1'b0;
		end else if (cap_hit) begin
			capture_irq_flag <= 1'b1;
		end else if (wr_st & wdata[0]) begin
			capture_irq_flag <= 1'b0;
		end
	end

	// read mux; unmapped reads give zero
	always @* begin
		case (addr)
			`DUT_ADDR_CORE_CTRL:  rdata_d = core_ctrl_q;
			`DUT_ADDR_AUX_CTRL:   rdata_d = aux_ctrl_q;
			`DUT_ADDR_CORE_TIMER: rdata_d = core_q;
			`DUT_ADDR_AUX_TIMER:  rdata_d = aux_q;
			`DUT_ADDR_CAPTURE_RELOAD_REGISTER:     rdata_d = capture_reload_register_q;
			`DUT_ADDR_STATUS:     rdata_d = {15'h0000, capture_irq_flag};
			default:              rdata_d = 16'h0000;
		endcase
	end

	always @(posedge clk) begin
		if (reset) begin
			rdata <= 16'h0000;
		end else if (rd) begin
			rdata <= rdata_d;
		end else begin
			rdata <= 16'h0000;
		end
	end

endmodule // dut_timer

// ===== verification/dutb_checker.sv
// port assertions for the dual timer block
`include "dut_consts.vh"
module dutb_checker (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	input wire logic        capture_input_pin,
	input wire logic        port_out_value,
	input wire logic        toggle_output_pin,
	input wire logic        core_wrap_pulse,
	input wire logic        capture_irq_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] aux_q;
	logic [3:0]  age_q;
	logic        oe_q, otl_q, run_q;
	wire         cw = wr && addr == `DUT_ADDR_CORE_CTRL;
	always_ff @(posedge clk) begin
		if (reset) begin
			{aux_q, age_q, oe_q, otl_q, run_q} <= '0;
		end else begin
			if (wr && addr == `DUT_ADDR_AUX_CTRL) aux_q <= wdata;
			if (cw) {oe_q, run_q} <= {wdata[9], wdata[6]};
			// wrap toggle beats a software write
			otl_q <= core_wrap_pulse ? !otl_q : cw ? wdata[10] : otl_q;
			age_q <= $changed(capture_input_pin) ? 4'h0 : age_q + 4'(age_q != 4'hf);
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_ar; rd && addr == `DUT_ADDR_AUX_CTRL; endsequence
	sequence s_cr; rd && addr == `DUT_ADDR_CORE_CTRL; endsequence
	property p_aux_rd; s_ar |=> rdata == ($past(aux_q) & `DUT_AUX_CTRL_MASK); endproperty
	a_aux_rd: assert property (p_aux_rd) else $error("aux readback");
	property p_rsv; s_cr |=> (rdata & ~`DUT_CORE_CTRL_MASK) == 16'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_port; !oe_q |-> toggle_output_pin == port_out_value; endproperty
	a_port: assert property (p_port) else $error("pin not port value");
	property p_latch; oe_q |-> toggle_output_pin == otl_q; endproperty
	a_latch: assert property (p_latch) else $error("pin not latch");
	property p_run; !run_q |-> !core_wrap_pulse; endproperty
	a_run: assert property (p_run) else $error("wrap while stopped");
	property p_pulse; core_wrap_pulse |=> !core_wrap_pulse [*3]; endproperty
	a_pulse: assert property (p_pulse) else $error("wrap pulse too long");
	property p_clr;
		$fell(capture_irq_flag) |-> $past(wr && addr == `DUT_ADDR_STATUS && wdata[0]);
	endproperty
	a_clr: assert property (p_clr) else $error("flag fell unasked");
	property p_src; $rose(capture_irq_flag) |-> age_q < 4'h8; endproperty
	a_src: assert property (p_src) else $error("flag without capture");
endmodule // dutb_checker
bind dut_timer dutb_checker u_chk (.*);

// ===== verification/dutb_pins.sv
// count and gate pin source at the pin side
module dutb_pins (
	input wire logic clk,
	input wire logic en,
	input wire logic lvl,
	output logic     pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt_q;
	always @(posedge clk) begin
		cnt_q <= en && cnt_q != 3'h4 ? cnt_q + 3'h1 : 3'h0;
		if (!en) pin <= lvl;
		else if (cnt_q == 3'h4) pin <= !pin;
	end
endmodule // dutb_pins

// ===== verification/tb.sv
// self-checking bench for the dual timer block
`include "dut_consts.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'h0, reset = 1'h1, wr = 1'h0, rd = 1'h0, rd_q = 1'h0, gate = 1'h0;
	logic        dpin = 1'h0, cpin = 1'h0, pov = 1'h0, en = 1'h0, cnt_pin;
	logic [15:0] addr = 16'h0, wdata = 16'h0, rdata, v, cap = 16'h0, exp_q[$];
	logic [31:0] seed = 32'h1624;
	int          error_cnt = 0, num_checks = 0, n;
	always #2 clk = !clk;
	dutb_pins PIN (.clk(clk), .en(en), .lvl(gate), .pin(cnt_pin));
	dut_timer DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .core_gate_count_pin(cnt_pin), .core_dir_pin(dpin),
		.aux_gate_count_pin(1'h0), .aux_dir_pin(1'h0), .capture_input_pin(cpin),
		.port_out_value(pov), .toggle_output_pin(), .core_wrap_pulse(), .capture_irq_flag());
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic bus(input logic w, input logic [15:0] a, d);
		@(posedge clk);
		{wr, rd, addr, wdata} <= {w, !w, a, d};
		@(posedge clk);
		{wr, rd} <= 2'h0;
	endtask
	task automatic chk(input logic [15:0] a, e);
		exp_q.push_back(e);
		bus(1'h0, a, 16'h0);
	endtask
	task automatic final_report;
		if (error_cnt == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) begin
		rd_q <= rd;
		if (rd_q) begin
			num_checks++;
			if (rdata !== exp_q[0]) begin
				error_cnt++;
				$display("[ERR] %0t got %h exp %h", $time, rdata, exp_q[0]);
			end
			void'(exp_q.pop_front());
		end
	end
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		final_report;
	end
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'h0;
		chk(`DUT_ADDR_CORE_CTRL, `DUT_CTRL_RESET);
		chk(16'h1234, 16'h0);
		seed = lfsr(seed);
		bus(1'h1, `DUT_ADDR_AUX_CTRL, seed[15:0]);
		chk(`DUT_ADDR_AUX_CTRL, seed[15:0] & `DUT_AUX_CTRL_MASK);
		bus(1'h1, `DUT_ADDR_AUX_CTRL, 16'h0);
		// timer codes 0..7, then gated low/high against both gate levels
		for (int k = 0; k < 12; k++) begin
			seed = lfsr(seed);
			{dpin, pov, gate} <= {seed[0], seed[1], k[1]};
			n = k < 8 ? 4 << k : 4;
			v = {6'h0, k[2:0], 1'h1, k < 8 ? 3'h0 : {2'h1, k[0]}, k < 8 ? k[2:0] : 3'h0};
			bus(1'h1, `DUT_ADDR_CORE_TIMER, 16'h0);
			repeat (4) @(posedge clk);
			bus(1'h1, `DUT_ADDR_CORE_CTRL, v);
			// window of exactly eight prescaled ticks
			repeat (8 * n - 2) @(posedge clk);
			bus(1'h1, `DUT_ADDR_CORE_CTRL, 16'h0);
			v = k < 8 || k[0] == k[1] ? 16'h8 : 16'h0;
			chk(`DUT_ADDR_CORE_TIMER, (k[1] ? k[0] ^ dpin : k[0]) ? -v : v);
		end
		gate <= 1'h0;
		for (int e = 0; e < 4; e++) begin
			bus(1'h1, `DUT_ADDR_CORE_TIMER, 16'h0);
			bus(1'h1, `DUT_ADDR_CORE_CTRL, {14'h12, e[1:0]});
			en <= 1'h1;
			repeat (30) @(posedge clk);
			en <= 1'h0;
			repeat (6) @(posedge clk);
			bus(1'h1, `DUT_ADDR_CORE_CTRL, 16'h0);
			chk(`DUT_ADDR_CORE_TIMER, e == 3 ? 16'h6 : e ? 16'h3 : 16'h0);
		end
		for (int c = 0; c < 4; c++) begin
			seed = lfsr(seed);
			bus(1'h1, `DUT_ADDR_AUX_TIMER, seed[15:0]);
			bus(1'h1, `DUT_ADDR_STATUS, 16'h1);
			bus(1'h1, `DUT_ADDR_AUX_CTRL, {1'h1, c[0], c[1:0], 12'h0});
			repeat (2) begin
				cpin <= !cpin;
				repeat (8) @(posedge clk);
			end
			if (c != 0) cap = c == 3 ? 16'h0 : seed[15:0];
			chk(`DUT_ADDR_CAPTURE_RELOAD_REGISTER, cap);
			chk(`DUT_ADDR_AUX_TIMER, c[0] ? 16'h0 : seed[15:0]);
			chk(`DUT_ADDR_STATUS, {15'h0, c != 0});
		end
		// one core wrap with reload; aux counts latch toggles downward
		seed = lfsr(seed);
		bus(1'h1, `DUT_ADDR_CAPTURE_RELOAD_REGISTER, seed[15:0]);
		bus(1'h1, `DUT_ADDR_AUX_TIMER, 16'h0);
		bus(1'h1, `DUT_ADDR_AUX_CTRL, 16'h00cf);
		bus(1'h1, `DUT_ADDR_CORE_TIMER, 16'hfffc);
		bus(1'h1, `DUT_ADDR_CORE_CTRL, 16'h8040);
		repeat (30) @(posedge clk);
		bus(1'h1, `DUT_ADDR_CORE_CTRL, 16'h0);
		chk(`DUT_ADDR_CORE_TIMER, seed[15:0] + 16'h4);
		chk(`DUT_ADDR_AUX_TIMER, 16'hffff);
		final_report;
	end
endmodule // tb
